// ===== inc/sau_agen_if.sv
// carrier between the store unit and its address generator
// assumes both ends sit in the same clockless combinational path
`timescale 1ns/100ps
interface sau_agen_if;
  logic [31:0] base; // base register value
  logic [31:0] offset; // offset already scaled to bytes
  logic sub; // subtract offset instead of adding
  logic circ; // apply circular wrap
  logic [4:0] blk_n; // block size field, size is 2^(n+1) bytes
  logic [31:0] addr; // computed address

  // store unit drives operands and reads the result
  modport user (output base, output offset, output sub, output circ, output blk_n, input addr);
  // generator reads operands and drives the result
  modport gen (input base, input offset, input sub, input circ, input blk_n, output addr);
endinterface : sau_agen_if

// ===== inc/sau_pkg.sv
// constants and types shared by the store address unit
// assumes a single cpu clock and a 32-bit data memory with byte lanes
package sau_pkg;

  // store width carried with each store request
  typedef enum logic [1:0] {
    SAU_BYTE,
    SAU_HALF,
    SAU_WORD
  } sau_width_t;

  // circular mode field codes inside the addressing mode register
  localparam logic [1:0] SAU_AM_LINEAR = 2'h0;
  localparam logic [1:0] SAU_AM_CIRC_BK0 = 2'h1;
  localparam logic [1:0] SAU_AM_CIRC_BK1 = 2'h2;

  // addressing mode register layout
  localparam int SAU_AM_FIELD_W = 2;
  localparam int SAU_AM_BK0_LSB = 16;
  localparam int SAU_AM_BK1_LSB = 21;
  localparam int SAU_AM_BK_W = 5;
  localparam logic [31:0] SAU_AMR_RESET = 32'h0000_0000;
  localparam logic [31:0] SAU_AMR_MASK = 32'h03FF_FFFF;

  // first and last base register number eligible for circular mode
  localparam logic [4:0] SAU_CIRC_FIRST = 5'h04;
  localparam logic [4:0] SAU_CIRC_LAST = 5'h07;

  // address mode field bit positions of a short-form store
  localparam int SAU_MODE_ADD = 0;
  localparam int SAU_MODE_POST = 1;
  localparam int SAU_MODE_REG = 2;
  localparam int SAU_MODE_MODIFY = 3;

  // offset widths and scaling shifts
  localparam int SAU_SHORT_OFS_W = 5;
  localparam int SAU_LONG_OFS_W = 15;
  localparam logic [1:0] SAU_SHIFT_BYTE = 2'h0;
  localparam logic [1:0] SAU_SHIFT_HALF = 2'h1;
  localparam logic [1:0] SAU_SHIFT_WORD = 2'h2;

  // default offsets when none is coded
  localparam logic [31:0] SAU_DEF_STEP = 32'h0000_0001;
  localparam logic [31:0] SAU_DEF_OFS = 32'h0000_0000;

  // wishbone register byte offsets
  localparam logic [7:0] SAU_REG_AMR = 8'h00;
  localparam logic [7:0] SAU_REG_LAST_ADDR = 8'h04;
  localparam logic [7:0] SAU_REG_COUNTS = 8'h08;

  // reset values of status state
  localparam logic [31:0] SAU_LAST_ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] SAU_CNT_RESET = 16'h0000;

endpackage : sau_pkg

// ===== rtl/sau_addr_gen.sv
// linear or circular address adder for the store unit
// assumes the offset is already scaled and smaller than the circular block
// and that the caller asks for wrap only on short-form stores
`timescale 1ns/100ps
module sau_addr_gen
  import sau_pkg::*;
(
  sau_agen_if.gen agen
);

  // low-bit mask of a circular block of 2^(n+1) bytes
  function automatic logic [31:0] blk_mask(input logic [4:0] n);
    logic [32:0] size;
    size = 33'h0_0000_0001 << ({1'b0, n} + 6'h01);
    return size[31:0] - 32'h0000_0001;
  endfunction : blk_mask

  logic [31:0] sum; // plain linear result
  logic [31:0] mask; // bits that wrap inside the block

  // add or subtract, then keep the upper bits of the base when circular
  always_comb begin
    sum = agen.sub ? (agen.base - agen.offset) : (agen.base + agen.offset);
    mask = blk_mask(agen.blk_n);
    if (agen.circ) begin
      agen.addr = (agen.base & ~mask) | (sum & mask);
    end else begin
      agen.addr = sum;
    end
  end

endmodule : sau_addr_gen

// ===== rtl/sau_top.sv
// store address unit: byte, halfword and word stores of both data units
// assumes register file values arrive on ports in the issue cycle and
// that the data memory takes one store per cycle without stalling
//
// Function
// - long form base: data page or stack
// - long form only on second data unit
// - long byte offset is not scaled
// - halfword offsets shifted left one bit
// - short word offset shifted left two bits
// - long form always adds, always linear
// - byte store writes low eight bits
// - halfword store writes low sixteen bits
// - word store writes all 32 bits
// - source file chosen by source select bit
// - short form side picks the base and offset register file
// - short offset: register or 5-bit constant
// - post modes send base before update
// - A4-A7, B4-B7 may use circular mode
// - missing offset: step one, offset zero
`timescale 1ns/100ps
module sau_top
  import sau_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // store request
  input wire logic st_valid_i,
  input wire logic st_long_i,
  input wire logic st_unit_i,
  input wire sau_width_t st_width_i,
  input wire logic st_side_i,
  input wire logic st_src_side_i,
  input wire logic [3:0] st_mode_i,
  input wire logic st_ofs_given_i,
  input wire logic [14:0] st_cst_i,
  input wire logic [4:0] st_base_num_i,
  // register file values
  input wire logic [31:0] a_base_register_i,
  input wire logic [31:0] a_offset_register_i,
  input wire logic [31:0] b_base_register_i,
  input wire logic [31:0] b_offset_register_i,
  input wire logic [31:0] data_page_base_i,
  input wire logic [31:0] stack_base_i,
  input wire logic [31:0] a_src_i,
  input wire logic [31:0] b_src_i,
  // data memory write port
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  // base register update
  output logic upd_we_o,
  output logic upd_side_o,
  output logic [4:0] upd_num_o,
  output logic [31:0] upd_data_o,
  // long form refused on the first unit
  output logic st_reject_o
);

  // offsets count units of the store width, so they are scaled to bytes
  // shift amount for a store width
  function automatic logic [1:0] width_shift(input sau_width_t w);
    case (w)
      SAU_BYTE: return SAU_SHIFT_BYTE; // no scaling
      SAU_HALF: return SAU_SHIFT_HALF;
      SAU_WORD: return SAU_SHIFT_WORD;
      default: return SAU_SHIFT_BYTE;
    endcase
  endfunction : width_shift

  // no alignment check: a misaligned halfword or word is the program's fault
  // byte lanes written for a width at a byte address
  function automatic logic [3:0] lanes(input sau_width_t w, input logic [1:0] a);
    case (w)
      SAU_BYTE: return 4'h1 << a;
      SAU_HALF: return a[1] ? 4'hC : 4'h3;
      default: return 4'hF;
    endcase
  endfunction : lanes

  // registers
  logic [31:0] amr_q; // addressing mode register
  logic [31:0] last_addr_q; // address of the last store sent
  logic [15:0] store_cnt_q; // stores sent
  logic [15:0] reject_cnt_q; // stores refused
  logic ack_q; // bus acknowledge
  logic [31:0] rdat_q; // bus read data

  // combinational decode of the store issued this cycle
  // decode wires
  logic accept; // store taken this cycle
  logic reject; // long form on the wrong unit
  logic [31:0] base; // selected base value
  logic [31:0] raw_ofs; // offset before scaling
  logic [31:0] scaled_ofs; // offset in bytes
  logic modify; // pre or post modify mode
  logic post; // post modify mode
  logic sub; // subtract offset
  logic circ_reg; // base register can be circular
  logic [3:0] field_idx; // circular field index
  logic [1:0] am_field; // mode field of that register
  logic [31:0] addr; // address sent to memory
  logic [31:0] src; // selected source value
  logic [31:0] wdata; // replicated store data
  logic bus_req; // new bus request this cycle

  // operands and result of the shared address adder
  sau_agen_if agen_if ();

  // one adder serves both forms; the long form never asks for wrap
  sau_addr_gen u_agen (
    .agen(agen_if.gen)
  );

  // the first unit has no path to the data page and stack bases
  // refuse long forms not issued on the second unit
  always_comb begin
    reject = st_valid_i & st_long_i & ~st_unit_i;
    accept = st_valid_i & ~reject;
  end

  // pick base and offset by form and side
  always_comb begin
    if (st_long_i) begin
      base = st_side_i ? stack_base_i : data_page_base_i;
      raw_ofs = {17'h0_0000, st_cst_i};
    end else begin
      base = st_side_i ? b_base_register_i : a_base_register_i;
      if (!st_ofs_given_i) begin
        // the default step is applied before scaling, so it moves one whole unit
        raw_ofs = st_mode_i[SAU_MODE_MODIFY] ? SAU_DEF_STEP : SAU_DEF_OFS;
      end else if (st_mode_i[SAU_MODE_REG]) begin
        // offset register shares the base side
        raw_ofs = st_side_i ? b_offset_register_i : a_offset_register_i;
      end else begin
        raw_ofs = {27'h000_0000, st_cst_i[SAU_SHORT_OFS_W-1:0]};
      end
    end
    // scaling by width holds for both the short and the long form
    scaled_ofs = raw_ofs << width_shift(st_width_i);
  end

  // only the short form modifies a base or wraps; the long form always adds
  // mode bits, direction and circular eligibility
  always_comb begin
    modify = ~st_long_i & st_mode_i[SAU_MODE_MODIFY];
    post = modify & st_mode_i[SAU_MODE_POST];
    sub = ~st_long_i & ~st_mode_i[SAU_MODE_ADD];
    circ_reg = ~st_long_i & (st_base_num_i >= SAU_CIRC_FIRST) & (st_base_num_i <= SAU_CIRC_LAST);
    // registers A4-A7 own fields 0 to 3 and B4-B7 fields 4 to 7, two bits each
    field_idx = {1'b0, st_side_i, st_base_num_i[1:0]};
    am_field = amr_q[field_idx[3:0] * SAU_AM_FIELD_W +: SAU_AM_FIELD_W];
  end

  // drive the address generator
  always_comb begin
    agen_if.base = base;
    agen_if.offset = scaled_ofs;
    agen_if.sub = sub;
    // long form stays linear whatever the mode register says
    agen_if.circ = circ_reg & ((am_field == SAU_AM_CIRC_BK0) | (am_field == SAU_AM_CIRC_BK1));
    // code 11 stays linear; the block size comes from field one only for code 10
    if (am_field == SAU_AM_CIRC_BK1) begin
      agen_if.blk_n = amr_q[SAU_AM_BK1_LSB +: SAU_AM_BK_W];
    end else begin
      agen_if.blk_n = amr_q[SAU_AM_BK0_LSB +: SAU_AM_BK_W];
    end
  end

  // narrow stores repeat the data across lanes; the lane enables pick the bytes
  // address and data to memory
  always_comb begin
    addr = post ? base : agen_if.addr;
    src = st_src_side_i ? b_src_i : a_src_i;
    case (st_width_i)
      SAU_BYTE: wdata = {4{src[7:0]}};
      SAU_HALF: wdata = {2{src[15:0]}};
      SAU_WORD: wdata = src;
      default: wdata = src;
    endcase
  end

  // address, data and lanes hold between stores; only the strobe pulses
  // memory write port, one cycle after issue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
      mem_be_o <= 4'h0;
    end else begin
      mem_we_o <= accept;
      if (accept) begin
        mem_addr_o <= addr;
        mem_wdata_o <= wdata;
        mem_be_o <= lanes(st_width_i, addr[1:0]);
      end
    end
  end

  // the new base is the adder result, also in post modes that send the old base
  // base register update for pre and post modify modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_we_o <= 1'b0;
      upd_side_o <= 1'b0;
      upd_num_o <= 5'h00;
      upd_data_o <= 32'h0000_0000;
    end else begin
      upd_we_o <= accept & modify;
      if (accept & modify) begin
        upd_side_o <= st_side_i;
        upd_num_o <= st_base_num_i;
        upd_data_o <= agen_if.addr;
      end
    end
  end

  // one pulse per refused store, in step with the write strobe it replaces
  // refusal pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reject_o <= 1'b0;
    end else begin
      st_reject_o <= reject;
    end
  end

  // both counters wrap; software reads them together in one access
  // status: last address and counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_addr_q <= SAU_LAST_ADDR_RESET;
      store_cnt_q <= SAU_CNT_RESET;
      reject_cnt_q <= SAU_CNT_RESET;
    end else begin
      if (accept) begin
        last_addr_q <= addr;
        store_cnt_q <= store_cnt_q + 16'h0001;
      end
      if (reject) begin
        reject_cnt_q <= reject_cnt_q + 16'h0001;
      end
    end
  end

  // a request is answered once; ack drops the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;

  // answering unmapped offsets too keeps a stray access from hanging the bus
  // bus acknowledge, also for unmapped offsets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // bits above the block size fields are masked and read back as zero
  // addressing mode register writes with byte selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amr_q <= SAU_AMR_RESET;
    end else if (bus_req && wb_we_i && wb_adr_i == SAU_REG_AMR) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          amr_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & SAU_AMR_MASK[i*8 +: 8];
        end
      end
    end
  end

  // the snapshot is taken at the request edge and shown with the acknowledge
  // read data, captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        SAU_REG_AMR: rdat_q <= amr_q;
        SAU_REG_LAST_ADDR: rdat_q <= last_addr_q;
        SAU_REG_COUNTS: rdat_q <= {reject_cnt_q, store_cnt_q};
        default: rdat_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // no logic stands between these flops and the pins
  // bus outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : sau_top

// ===== verification/sau_mem_model.sv
// byte-lane data memory seen by the store unit, 64 KiB window
// assumes the write port qualifies lanes by byte enables
`timescale 1ns/100ps
module sau_mem_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  input wire logic [15:0] look_i,
  output logic [31:0] look_o
);
  logic [7:0] mem [0:65535]; // filled with a marker so stray lanes show
  initial begin
    foreach (mem[i]) mem[i] = 8'hEE;
  end
  // only enabled lanes change, neighbours keep the marker
  always @(posedge clk_i) begin
    if (we_i) begin
      for (int k = 0; k < 4; k++) if (be_i[k]) mem[{addr_i[15:2], 2'h0} + 16'(k)] <= wdata_i[8*k +: 8];
    end
  end
  assign look_o = {mem[look_i + 16'h3], mem[look_i + 16'h2], mem[look_i + 16'h1], mem[look_i]};
endmodule : sau_mem_model

// ===== verification/sau_top_props.sv
// checker for the store address unit, watching top-level ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module sau_top_props
  import sau_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic st_valid_i,
  input wire logic st_long_i,
  input wire logic st_unit_i,
  input wire sau_width_t st_width_i,
  input wire logic st_side_i,
  input wire logic st_src_side_i,
  input wire logic [14:0] st_cst_i,
  input wire logic [31:0] data_page_base_i,
  input wire logic [31:0] stack_base_i,
  input wire logic [31:0] a_src_i,
  input wire logic [31:0] b_src_i,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic [3:0] mem_be_o,
  input wire logic st_reject_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] src_w; // store data picked by the source select
  logic [31:0] long_w; // expected long-form address
  logic acc_w; // store that must be accepted
  assign src_w = st_src_side_i ? b_src_i : a_src_i;
  assign long_w = (st_side_i ? stack_base_i : data_page_base_i)
    + ({17'h0_0000, st_cst_i} << (st_width_i == SAU_HALF ? 1 : (st_width_i == SAU_WORD ? 2 : 0)));
  assign acc_w = st_valid_i && !(st_long_i && !st_unit_i);
  // ack is a single-cycle pulse
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  rej_store_a: assert property (st_valid_i && st_long_i && !st_unit_i |=> st_reject_o && !mem_we_o)
    else $error("long store on first unit not refused");
  acc_store_a: assert property (acc_w |=> mem_we_o && !st_reject_o)
    else $error("accepted store gave no write");
  idle_store_a: assert property (!st_valid_i |=> !mem_we_o && !st_reject_o)
    else $error("write without a store");
  byte_lane_a: assert property (acc_w && st_width_i == SAU_BYTE |=>
    mem_be_o == (4'h1 << mem_addr_o[1:0]) && ((mem_wdata_o ^ $past(src_w)) & 32'h0000_00FF) == 32'h0)
    else $error("byte store lanes or data wrong");
  half_lane_a: assert property (acc_w && st_width_i == SAU_HALF |=>
    mem_be_o == (mem_addr_o[1] ? 4'hC : 4'h3) && ((mem_wdata_o ^ $past(src_w)) & 32'h0000_FFFF) == 32'h0)
    else $error("halfword store lanes or data wrong");
  word_data_a: assert property (acc_w && st_width_i == SAU_WORD |=>
    mem_be_o == 4'hF && mem_wdata_o == $past(src_w))
    else $error("word store lanes or data wrong");
  long_addr_a: assert property (acc_w && st_long_i |=> mem_addr_o == $past(long_w))
    else $error("long store address wrong");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_pulse_s)
    else $error("register access not acknowledged once");
endmodule : sau_top_props

// ===== verification/tb_top.sv
// self-checking bench: register bus and store traffic into a memory model
// assumes the design stores in one cycle; a bus wait ends on the acknowledge or the watchdog
`timescale 1ns/100ps
module tb_top;
  import sau_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, st_mode_i, mem_be_o;
  logic [31:0] wb_dat_i, wb_dat_o, mem_addr_o, mem_wdata_o, upd_data_o, look_word, rd;
  logic st_valid_i, st_long_i, st_unit_i, st_side_i, st_src_side_i, st_ofs_given_i;
  sau_width_t st_width_i;
  logic [14:0] st_cst_i;
  logic [4:0] st_base_num_i, upd_num_o;
  logic [31:0] a_base_register_i, a_offset_register_i, b_base_register_i, b_offset_register_i;
  logic [31:0] data_page_base_i, stack_base_i, a_src_i, b_src_i;
  logic mem_we_o, upd_we_o, upd_side_o, st_reject_o;
  logic [15:0] look;
  int miscompares = 0;
  int cmp_count = 0;
  sau_top i_dut (.*);
  sau_mem_model i_mem (.clk_i(clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .be_i(mem_be_o), .look_i(look), .look_o(look_word));
  // 100 ns clock
  always #50 clk_i = ~clk_i;
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle, read data lands in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // one store; f = {long, unit, side, source side, offset given}; no reserved bit is sent
  task automatic st(input logic [4:0] f, input sau_width_t w, input logic [3:0] m, input logic [14:0] c,
    input logic [4:0] num, input logic [31:0] ea, input logic [31:0] ew, input logic [31:0] eu);
    logic rej;
    rej = f[4] & ~f[3];
    @(posedge clk_i);
    {st_long_i, st_unit_i, st_side_i, st_src_side_i, st_ofs_given_i} <= f;
    st_width_i <= w;
    st_mode_i <= m;
    st_cst_i <= c;
    st_base_num_i <= num;
    st_valid_i <= 1'b1;
    @(posedge clk_i);
    st_valid_i <= 1'b0;
    look <= ea[15:0];
    #1;
    chk({31'h0, st_reject_o}, {31'h0, rej});
    chk({31'h0, mem_we_o}, {31'h0, !rej});
    if (!rej) chk(mem_addr_o, ea);
    if (m[3] && !f[4]) chk(upd_data_o, eu);
    chk({31'h0, upd_we_o}, {31'h0, m[3] & ~f[4]});
    if (m[3] && !f[4]) chk({26'h0, upd_side_o, upd_num_o}, {26'h0, f[2], num});
    @(posedge clk_i);
    #1;
    chk(look_word, ew);
  endtask : st
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, st_valid_i, st_long_i, st_unit_i} = 6'h00;
    {st_side_i, st_src_side_i, st_ofs_given_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    st_width_i = SAU_BYTE;
    st_mode_i = 4'h0;
    st_cst_i = 15'h0000;
    st_base_num_i = 5'h00;
    look = 16'h0000;
    a_base_register_i = 32'h0000_0108;
    a_offset_register_i = 32'h0000_0001;
    b_base_register_i = 32'h0000_0200;
    b_offset_register_i = 32'h0000_0002;
    data_page_base_i = 32'h0000_1000;
    stack_base_i = 32'h0000_2000;
    a_src_i = 32'h9A32_7634;
    b_src_i = 32'h1234_5678;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    st(5'h1B, SAU_BYTE, 4'h0, 15'h0028, 5'h0E, 32'h0000_1028, 32'hEEEE_EE78, 32'h0);
    st(5'h1F, SAU_HALF, 4'h0, 15'h0002, 5'h0F, 32'h0000_2004, 32'hEEEE_5678, 32'h0);
    st(5'h13, SAU_BYTE, 4'h0, 15'h0000, 5'h0E, 32'h0000_1000, 32'hEEEE_EEEE, 32'h0);
    st(5'h01, SAU_WORD, 4'hD, 15'h0000, 5'h0A, 32'h0000_010C, 32'h9A32_7634, 32'h0000_010C);
    st(5'h02, SAU_HALF, 4'hA, 15'h0000, 5'h0A, 32'h0000_0108, 32'hEEEE_5678, 32'h0000_0106);
    st(5'h05, SAU_HALF, 4'h5, 15'h0000, 5'h0A, 32'h0000_0204, 32'hEEEE_7634, 32'h0);
    wb(1'b1, 8'h00, 32'h0003_0001);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0003_0001);
    st(5'h03, SAU_WORD, 4'h1, 15'h0003, 5'h04, 32'h0000_0104, 32'h1234_5678, 32'h0);
    st(5'h03, SAU_WORD, 4'h1, 15'h0003, 5'h08, 32'h0000_0114, 32'h1234_5678, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0001_0007);
    wb(1'b1, 8'h00, 32'h0003_0100);
    st(5'h05, SAU_WORD, 4'h1, 15'h0005, 5'h04, 32'h0000_0204, 32'h9A32_7634, 32'h0);
    st(5'h01, SAU_HALF, 4'h0, 15'h0002, 5'h0A, 32'h0000_0104, 32'h1234_7634, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0104);
    complete_run;
  end
  // cut a hang short
  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    complete_run;
  end
endmodule : tb_top
bind sau_top sau_top_props u_props (.*);
